// ===== hw/msl_pkg.sv
// Purpose: Shared types and constants for the multi-unit sync link
// Assumes: Link words arrive already decoded, one per link clock
// Notes:   All timing figures are derived from named units below
package msl_pkg;
    // ---------------------------------------------------------------
    // Mode and symbol codes
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_ALONE  = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h1;
    localparam logic [1:0] MODE_SLAVE  = 2'h2;
    localparam logic [1:0] KIND_IDLE   = 2'h0;
    localparam logic [1:0] KIND_ALIGN  = 2'h1;
    localparam logic [1:0] KIND_DATA   = 2'h2;
    localparam int         TS_W        = 16;
    localparam int         RT_W        = 8;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int FIBER_MAX_M    = 500;
    localparam int FIBER_NS_PER_M = 5;
    localparam int LCLK_NS        = 64;
    localparam int SYNC_TOL_NS    = 100;
    localparam int ONEWAY_CYC     = (FIBER_MAX_M * FIBER_NS_PER_M + LCLK_NS - 1) / LCLK_NS;
    localparam int SKEW_CYC       = (SYNC_TOL_NS / LCLK_NS < 1) ? 1 : SYNC_TOL_NS / LCLK_NS;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {LS_NONE, LS_ALIGN, LS_DATA} msl_lstate_t;
    typedef struct packed {
        logic [1:0]      kind;
        logic            run;
        logic            trig;
        logic            echo;
        logic [TS_W-1:0] tstamp;
    } msl_word_t;
    typedef struct packed {
        logic      sig_det;
        msl_word_t w;
    } msl_rx_t;
endpackage

// ===== hw/msl_sync_top.sv
// Purpose: Mode, trigger, delay compensation and status for the sync link
// Assumes: lclk is the carried sampling clock; rx words are on lclk
// Notes:   Distribution bus is synchronous to lclk
//
// Behaviour
// - Master drives all ports as outgoing links
// - Master sends start and sync to all together
// - Master merges local and slave triggers globally
// - Slave uses top port only, others silent
// - Slave puts received signals on distribution bus
// - Slave returns local triggers to the master
// - Stand-alone exchanges nothing on any port
// - Link carries clock, time, trigger, start/stop
// - Master-slave alignment within 100 ns
// - Measure each fiber delay and compensate it
// - Support fiber spans up to 500 m
// - Two LEDs show none, aligning, receiving data
`timescale 1ns/1ps
module msl_sync_top import msl_pkg::*; #(
    parameter int NPORTS = 8,
    parameter int DLY    = ONEWAY_CYC
) (
    // Clocks and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            lclk,
    // Chassis control, clk domain
    input  wire logic [1:0]      mode_sel,
    input  wire logic            loc_trig,
    input  wire logic            rec_start,
    input  wire logic            drop_clr,
    // Fiber ports, lclk domain
    input  wire msl_rx_t         rx [NPORTS],
    output msl_word_t            tx [NPORTS],
    // Distribution bus, lclk domain
    output logic                 dist_run,
    output logic                 dist_trig,
    output logic [TS_W-1:0]      dist_time,
    // Status, clk domain
    output logic                 led_sig,
    output logic                 led_data,
    output msl_lstate_t          link_state,
    output logic                 link_drop
);
    localparam int NL   = NPORTS + 1;
    localparam int DW   = $clog2(DLY + 1);
    localparam int BND  = DLY + 4;
    localparam int CW   = $clog2(BND + 1);

    // ---------------------------------------------------------------
    // Link reset and crossings into lclk
    // ---------------------------------------------------------------
    logic [1:0] lrst_reg;
    logic       lrst_n;
    logic [1:0] mode_s1_reg, mode_s2_reg;
    logic       run_s1_reg, run_s2_reg;
    logic       tgl_reg, tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

    assign lrst_n = lrst_reg[1];

    always_ff @(posedge lclk or negedge resetn) begin
        if (!resetn) begin
            lrst_reg <= 2'h0;
        end else begin
            lrst_reg <= {lrst_reg[0], 1'b1};
        end
    end

    // Trigger pulses cross as a toggle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tgl_reg <= 1'b0;
        end else begin
            tgl_reg <= tgl_reg ^ loc_trig;
        end
    end

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            mode_s1_reg <= MODE_ALONE;
            mode_s2_reg <= MODE_ALONE;
            run_s1_reg  <= 1'b0;
            run_s2_reg  <= 1'b0;
            tgl_s1_reg  <= 1'b0;
            tgl_s2_reg  <= 1'b0;
            tgl_s3_reg  <= 1'b0;
        end else begin
            mode_s1_reg <= mode_sel;
            mode_s2_reg <= mode_s1_reg;
            run_s1_reg  <= rec_start;
            run_s2_reg  <= run_s1_reg;
            tgl_s1_reg  <= tgl_reg;
            tgl_s2_reg  <= tgl_s1_reg;
            tgl_s3_reg  <= tgl_s2_reg;
        end
    end

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    function automatic msl_lstate_t port_state(input msl_rx_t r);
        if (!r.sig_det || r.w.kind == KIND_IDLE) begin
            return LS_NONE;
        end else if (r.w.kind == KIND_ALIGN) begin
            return LS_ALIGN;
        end
        return (r.w.kind == KIND_DATA) ? LS_DATA : LS_NONE;
    endfunction

    wire         is_m    = (mode_s2_reg == MODE_MASTER);
    wire         is_s    = (mode_s2_reg == MODE_SLAVE);
    wire         ltrig   = tgl_s2_reg ^ tgl_s3_reg;
    wire         top_dat = (port_state(rx[0]) == LS_DATA);

    logic [NPORTS-1:0] p_dat, p_sig, p_trg;
    logic [NL-1:0]     tap_run, tap_trg;
    logic [RT_W-1:0]   rt_reg [NL];
    logic [TS_W-1:0]   time_reg;

    wire gtrig = ltrig | (|(p_trg & p_dat));

    // Master cycles with the run level up, for the start check
    logic [CW-1:0] mrun_cnt_reg;

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            mrun_cnt_reg <= '0;
        end else if (!(is_m && run_s2_reg)) begin
            mrun_cnt_reg <= '0;
        end else if (mrun_cnt_reg != CW'(BND)) begin
            mrun_cnt_reg <= mrun_cnt_reg + CW'(1);
        end
    end

    // ---------------------------------------------------------------
    // Per-line delay measurement and equalising delay
    // ---------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < NL; gp++) begin : g_line
            logic [DLY:0][1:0] sr_reg;
            logic [RT_W-1:0]   cnt_reg;
            logic              ping_reg;
            logic [DW-1:0]     dly;
            wire  [RT_W-1:0]   half = rt_reg[gp] >> 1;

            // Lines with longer fiber wait less before sending
            assign dly = (half >= RT_W'(DLY)) ? DW'(0) : DW'(DLY - int'(half));
            assign tap_run[gp] = sr_reg[dly][1];
            assign tap_trg[gp] = sr_reg[dly][0];

            always_ff @(posedge lclk or negedge lrst_n) begin
                if (!lrst_n) begin
                    sr_reg <= '0;
                end else begin
                    sr_reg <= {sr_reg[DLY-1:0], {run_s2_reg, gtrig}};
                end
            end

            if (gp < NPORTS) begin : g_port
                assign p_dat[gp] = (port_state(rx[gp]) == LS_DATA);
                assign p_sig[gp] = (port_state(rx[gp]) != LS_NONE);
                assign p_trg[gp] = rx[gp].w.trig;
                wire echo_back = p_dat[gp] && (rx[gp].w.echo == ping_reg);

                always_ff @(posedge lclk or negedge lrst_n) begin
                    if (!lrst_n) begin
                        cnt_reg    <= '0;
                        ping_reg   <= 1'b0;
                        rt_reg[gp] <= '0;
                    end else if (echo_back && is_m) begin
                        rt_reg[gp] <= cnt_reg;
                        cnt_reg    <= '0;
                        ping_reg   <= ~ping_reg;
                    end else if (cnt_reg != '1) begin
                        cnt_reg <= cnt_reg + RT_W'(1);
                    end
                end

                always_ff @(posedge lclk or negedge lrst_n) begin
                    if (!lrst_n) begin
                        tx[gp] <= '0;
                    end else if (is_m) begin
                        tx[gp] <= {KIND_DATA, tap_run[gp], tap_trg[gp], ping_reg,
                                   TS_W'(time_reg + TS_W'(half))};
                    end else if (is_s && gp == 0) begin
                        tx[gp] <= {top_dat ? KIND_DATA : KIND_ALIGN, 1'b0, ltrig,
                                   rx[0].w.echo, TS_W'(0)};
                    end else begin
                        tx[gp] <= '0;
                    end
                end

                chk_master_ports: assert property (@(posedge lclk) disable iff (!lrst_n)
                    is_m && $past(is_m) |-> tx[gp].kind == KIND_DATA)
                    else $error("master port not sending data");
                chk_slave_quiet: assert property (@(posedge lclk) disable iff (!lrst_n)
                    (gp > 0) && is_s && $past(is_s) |-> tx[gp] == '0)
                    else $error("slave side port active");
                chk_alone_quiet: assert property (@(posedge lclk) disable iff (!lrst_n)
                    !is_m && !is_s && $past(!is_m && !is_s) |-> tx[gp].kind == KIND_IDLE)
                    else $error("stand-alone port active");
                chk_start_all: assert property (@(posedge lclk) disable iff (!lrst_n)
                    mrun_cnt_reg == CW'(BND) |-> tx[gp].run)
                    else $error("start not sent on port");
                chk_trig_merge: assert property (@(posedge lclk) disable iff (!lrst_n)
                    is_m && p_dat[gp] && p_trg[gp] |-> ##[1:BND] (tx[0].trig || !is_m))
                    else $error("slave trigger not merged");
            end else begin : g_local
                assign rt_reg[gp] = '0;
                assign cnt_reg    = '0;
                assign ping_reg   = 1'b0;
            end

            chk_equal_delay: assert property (@(posedge lclk) disable iff (!lrst_n)
                (rt_reg[gp] < RT_W'(2 * DLY)) |->
                (2 * int'(dly) + int'(rt_reg[gp]) - 2 * DLY) inside {0, 1})
                else $error("delay compensation off");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Absolute time and distribution bus
    // ---------------------------------------------------------------
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            time_reg  <= '0;
            dist_run  <= 1'b0;
            dist_trig <= 1'b0;
            dist_time <= '0;
        end else begin
            time_reg <= time_reg + TS_W'(1);
            if (is_m) begin
                dist_run  <= tap_run[NPORTS];
                dist_trig <= tap_trg[NPORTS];
                dist_time <= time_reg;
            end else if (is_s) begin
                dist_run  <= top_dat & rx[0].w.run;
                dist_trig <= top_dat & rx[0].w.trig;
                dist_time <= top_dat ? rx[0].w.tstamp : dist_time + TS_W'(1);
            end else begin
                dist_run  <= run_s2_reg;
                dist_trig <= ltrig;
                dist_time <= dist_time + TS_W'(1);
            end
        end
    end

    chk_slave_bus: assert property (@(posedge lclk) disable iff (!lrst_n)
        is_s && top_dat |=> dist_time == $past(rx[0].w.tstamp) && dist_run == $past(rx[0].w.run))
        else $error("slave bus not following link");
    chk_slave_trig: assert property (@(posedge lclk) disable iff (!lrst_n)
        is_s [*3] ##0 $rose(tgl_s2_reg ^ tgl_s3_reg) |-> ##1 tx[0].trig)
        else $error("slave trigger not returned");
    chk_alone_bus: assert property (@(posedge lclk) disable iff (!lrst_n)
        !is_m && !is_s |=> dist_run == $past(run_s2_reg))
        else $error("stand-alone bus not local");

    // ---------------------------------------------------------------
    // Link status into clk
    // ---------------------------------------------------------------
    logic sig_l_reg, dat_l_reg;
    logic sig_c1_reg, dat_c1_reg, dat_prev_reg;

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            sig_l_reg <= 1'b0;
            dat_l_reg <= 1'b0;
        end else begin
            sig_l_reg <= is_m ? |p_sig : (is_s & p_sig[0]);
            dat_l_reg <= is_m ? |p_dat : (is_s & p_dat[0]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sig_c1_reg   <= 1'b0;
            dat_c1_reg   <= 1'b0;
            led_sig      <= 1'b0;
            led_data     <= 1'b0;
            dat_prev_reg <= 1'b0;
            link_state   <= LS_NONE;
            link_drop    <= 1'b0;
        end else begin
            sig_c1_reg   <= sig_l_reg;
            dat_c1_reg   <= dat_l_reg;
            led_sig      <= sig_c1_reg | dat_c1_reg;
            led_data     <= dat_c1_reg;
            dat_prev_reg <= led_data;
            link_state   <= led_data ? LS_DATA : (led_sig ? LS_ALIGN : LS_NONE);
            if (dat_prev_reg && !led_data) begin
                link_drop <= 1'b1;
            end else if (drop_clr) begin
                link_drop <= 1'b0;
            end
        end
    end

    chk_led_combo: assert property (@(posedge clk) disable iff (!resetn)
        led_data |-> led_sig)
        else $error("data LED without signal LED");
    chk_drop_flag: assert property (@(posedge clk) disable iff (!resetn)
        dat_prev_reg && !led_data ##1 !drop_clr |-> link_drop ##1 link_drop)
        else $error("drop not flagged or lost");
endmodule

// ===== test/msl_peer_model.sv
// Purpose: Far-side sync card on one fiber, with its own fiber delay
// Assumes: One word per lclk in each direction, fixed delay of DEPTH words down and DEPTH+1 words up
// Notes:   A released link drops signal detect and inverts its last word every cycle
`timescale 1ns/1ps
module msl_peer_model import msl_pkg::*; #(
    parameter int DEPTH = 2
) (
    // Clock and role
    input  wire logic      lclk,
    input  wire logic      en,
    input  wire logic      as_master,
    input  wire logic      aligning,
    input  wire logic      run,
    input  wire logic      trig,
    // Single fiber, one DUT port
    input  wire msl_word_t from_dut,
    output msl_rx_t        to_dut,
    output logic           got_run
);
    // ---------------------------------------------------------------
    // Fiber delay and reply
    // ---------------------------------------------------------------
    msl_word_t       dn [DEPTH];
    msl_word_t       up [DEPTH];
    msl_word_t       rep;
    logic [TS_W-1:0] cnt = '0;
    initial to_dut = '0;
    assign got_run = dn[DEPTH-1].run;
    always_comb begin
        rep.kind   = aligning ? KIND_ALIGN : KIND_DATA;
        rep.run    = as_master & run;
        rep.trig   = trig;
        rep.echo   = as_master ? cnt[2] : dn[DEPTH-1].echo;
        rep.tstamp = cnt;
    end
    always @(posedge lclk) begin
        cnt   <= cnt + 16'h0001;
        dn[0] <= from_dut;
        up[0] <= rep;
        for (int i = 1; i < DEPTH; i++) begin
            dn[i] <= dn[i-1];
            up[i] <= up[i-1];
        end
        to_dut <= en ? {1'b1, up[DEPTH-1]} : {1'b0, ~to_dut.w};
    end
endmodule

// ===== test/multi_unit_sync_link_test.sv
// Purpose: Self-checking bench for the multi-unit sync link
// Assumes: Cards on ports 0 and 1 at different fiber lengths, ports 2 and 3 loose
// Notes:   Short delay line keeps the run brief
`timescale 1ns/1ps
module multi_unit_sync_link_test import msl_pkg::*; ;
    localparam int NP = 4;
    logic            clk = 0, lclk = 0, resetn = 0;
    logic [1:0]      mode_sel = MODE_ALONE;
    logic            loc_trig = 0, rec_start = 0, drop_clr = 0;
    msl_rx_t         rx [NP];
    msl_word_t       tx [NP];
    msl_rx_t         r0, r1;
    msl_rx_t         junk [2] = '{default: '0};
    logic            dist_run, dist_trig, led_sig, led_data, link_drop;
    logic [TS_W-1:0] dist_time, pts;
    msl_lstate_t     link_state;
    logic [1:0]      pen = 0, ptrig = 0, grun;
    logic            pm = 0, pal = 0, prun = 0, slv = 0;
    logic [2:0]      prv = 0, cur;
    int              err_count = 0, n_checks = 0, lc = 0, n_dt = 0, n_tt = 0, k;
    int              tr [3] = '{100, 200, 300};
    int              seed = 32'hedb6536a;

    initial forever #20 clk = ~clk;
    initial begin
        #13;
        forever #32 lclk = ~lclk;
    end
    assign rx = '{r0, r1, junk[0], junk[1]};
    msl_sync_top #(.NPORTS(NP), .DLY(8)) dut (.clk(clk), .resetn(resetn), .lclk(lclk), .mode_sel(mode_sel),
        .loc_trig(loc_trig), .rec_start(rec_start), .drop_clr(drop_clr), .rx(rx), .tx(tx), .dist_run(dist_run),
        .dist_trig(dist_trig), .dist_time(dist_time), .led_sig(led_sig), .led_data(led_data),
        .link_state(link_state), .link_drop(link_drop));
    msl_peer_model #(.DEPTH(2)) p0 (.lclk(lclk), .en(pen[0]), .as_master(pm), .aligning(pal), .run(prun),
        .trig(ptrig[0]), .from_dut(tx[0]), .to_dut(r0), .got_run(grun[0]));
    msl_peer_model #(.DEPTH(5)) p1 (.lclk(lclk), .en(pen[1]), .as_master(pm), .aligning(pal), .run(prun),
        .trig(ptrig[1]), .from_dut(tx[1]), .to_dut(r1), .got_run(grun[1]));

    // Loose ports carry random data words, with signal detect set from the slave scenario onward
    always @(negedge lclk) begin
        for (int i = 0; i < 2; i++) junk[i] <= {slv, KIND_DATA, 19'($random(seed))};
        lc++;
        cur = {dist_run, grun};
        for (int i = 0; i < 3; i++) if (cur[i] === 1'b1 && prv[i] !== 1'b1) tr[i] = lc;
        prv = cur;
        n_dt += (dist_trig === 1'b1);
        n_tt += (tx[0].trig === 1'b1);
    end

    task chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task lw(input int n);
        repeat (n) @(negedge lclk);
        @(negedge clk);
    endtask
    task pulse(input int which);
        @(negedge clk);
        if (which == 0) loc_trig = 1;
        else drop_clr = 1;
        @(negedge clk);
        loc_trig = 0;
        drop_clr = 0;
    endtask
    task ptrg(input logic [1:0] v);
        @(negedge lclk);
        ptrig = v;
        @(negedge lclk);
        ptrig = 0;
    endtask
    function automatic bit all_tx(input int what, input int from);
        bit r = 1;
        for (int p = from; p < NP; p++) begin
            if (what == 0) r &= (tx[p] === '0);
            if (what == 1) r &= (tx[p].kind === KIND_DATA || tx[p].kind === KIND_ALIGN);
            if (what == 2) r &= (tx[p].run === 1'b1);
        end
        return r;
    endfunction
    function automatic bit leds_ok(input msl_lstate_t s);
        return led_sig === (s != LS_NONE) && led_data === (s == LS_DATA) && link_state === s;
    endfunction
    task summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios: master, slave, stand-alone
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1;
        chk(all_tx(0, 0) && leds_ok(LS_NONE) && link_drop === 1'b0, "reset outputs");
        mode_sel = MODE_MASTER;
        pen = 2'b11;
        lw(80);
        chk(all_tx(1, 0), "master port silent");
        chk(leds_ok(LS_DATA), "master leds");
        rec_start = 1;
        lw(40);
        chk(all_tx(2, 0), "run missing on a port");
        chk(tr[0] - tr[1] <= 1 && tr[1] - tr[0] <= 1, "arrival skew");
        chk(tr[2] - tr[0] <= SKEW_CYC + 1 && tr[0] - tr[2] <= SKEW_CYC + 1, "local vs remote");
        for (int i = 0; i < 3; i++) begin
            k = n_dt;
            if (i == 0) pulse(0);
            else ptrg(2'(i));
            lw(30 + {$random(seed)} % 8);
            chk(n_dt > k, "global trigger missing");
        end
        pal = 1;
        lw(30);
        chk(leds_ok(LS_ALIGN), "align leds");
        chk(link_drop === 1'b1, "drop not flagged");
        pulse(1);
        lw(2);
        chk(link_drop === 1'b0, "drop not cleared");
        pen = 0;
        lw(30);
        chk(leds_ok(LS_NONE), "dark leds");
        mode_sel = MODE_SLAVE;
        slv = 1;
        pm = 1;
        pal = 0;
        pen = 2'b11;
        lw(40);
        k = n_dt;
        lw(20);
        chk(n_dt == k && dist_run === 1'b0, "unused port heard");
        chk(all_tx(0, 1) && tx[0].kind === KIND_DATA, "slave port use");
        prun = 1;
        lw(20);
        chk(dist_run === 1'b1 && leds_ok(LS_DATA), "run not distributed");
        for (int i = 0; i < 8; i++) begin
            @(negedge lclk);
            if (i > 0) chk(dist_time === pts, "time not forwarded");
            pts = rx[0].w.tstamp;
        end
        k = n_tt;
        pulse(0);
        lw(20);
        chk(n_tt > k, "local trigger not returned");
        k = n_dt;
        ptrg(2'b01);
        lw(10);
        chk(n_dt > k, "master trigger not distributed");
        for (int i = 0; i < 2; i++) begin
            mode_sel = (i == 1) ? 2'h3 : MODE_ALONE;
            rec_start = i[0];
            lw(20);
            chk(all_tx(0, 0) && led_sig === 1'b0 && led_data === 1'b0, "alone port activity");
            chk(dist_run === rec_start, "alone run");
        end
        summarize();
    end
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
